// ### core/spio_pkg.sv
// Package with register map, field layout and carrier types of the shared parallel I/O port
package spio_pkg;

    // ******************************
    // Widths
    // ******************************
    localparam int PORT_W = 16;
    localparam int ADDR_W = 3;

    // ******************************
    // Register word offsets (Avalon word addresses)
    // ******************************
    localparam logic [2:0] OFS_DIR = 3'h0;
    localparam logic [2:0] OFS_LAT = 3'h1;
    localparam logic [2:0] OFS_PIN = 3'h2;
    localparam logic [2:0] OFS_ANA = 3'h3;
    localparam logic [2:0] OFS_PEN = 3'h4;

    // ******************************
    // Reset values
    // ******************************
    localparam logic [15:0] RST_DIR = 16'hFFFF;
    localparam logic [15:0] RST_LAT = 16'h0000;
    localparam logic [15:0] RST_ANA = 16'h0000;
    localparam logic [15:0] RST_PEN = 16'h0000;
    localparam logic [31:0] RD_ZERO = 32'h0000_0000;

    // ******************************
    // Cycle counts
    // ******************************
    localparam int SYNC_STAGES = 2;

    // ******************************
    // Carrier types
    // ******************************
    typedef struct packed {
        logic [15:0] out_data;
        logic [15:0] out_en;
    } spio_pad_type;

    typedef struct packed {
        logic [15:0] drive;
        logic [15:0] data;
        logic [15:0] enable;
    } spio_periph_type;

    typedef enum logic [2:0] {
        BUS_IDLE = 3'b001,
        BUS_RESP = 3'b010,
        BUS_DONE = 3'b100
    } spio_bus_state_type;

endpackage

// ### core/spio_port.sv
// Shared parallel I/O port with Avalon-MM register access
//
// Notes on behaviour
// - Actively driving enabled peripheral owns pad output; port driver off, pin still readable.
// - Enabled but idle peripheral leaves the pad to the port logic.
// - Direction bit one means input, zero means output.
// - Any reset sets all direction bits, so every pin is an input.
// - Latch register reads stored latch; writes update only the latch.
// - Pin-level register reads pins; writes go into the output latch.
// - Unimplemented bits read zero in latch, direction and pin-level registers.
// - Pin shared only with input peripherals is a dedicated port pin.
// - Two multiplexers choose peripheral or port for pad data and enable.
// - Analog config and direction registers jointly govern converter-capable pins.
// - Analog pin set to output feeds its output latch level to the converter, even while a peripheral drives the pad.
// - Pin-level read returns zero for bits configured as analog inputs.
// - A pin configured as digital input is not passed to the converter.
`timescale 1ns/1ps
`default_nettype none

module spio_port #(
    parameter logic [15:0] IMPL_MASK = 16'hFFFF,
    parameter logic [15:0] ANALOG_MASK = 16'h00FF,
    parameter logic [15:0] OUTPUT_PERIPH_MASK = 16'hFFFF
) (
    // Clock, reset and enable
    input wire logic CLK,
    input wire logic ARST_N,
    input wire logic CE,
    // Avalon-MM slave
    input wire logic [2:0] AVS_ADDRESS,
    input wire logic AVS_READ,
    input wire logic AVS_WRITE,
    input wire logic [31:0] AVS_WRITEDATA,
    input wire logic [3:0] AVS_BYTEENABLE,
    output logic [31:0] AVS_READDATA,
    output logic AVS_WAITREQUEST,
    // Peripheral side
    input wire spio_pkg::spio_periph_type PERIPH,
    // Pads
    input wire logic [15:0] PAD_IN,
    output var spio_pkg::spio_pad_type PAD_OUT,
    // Converter side
    output logic [15:0] ANALOG_SAMPLE,
    output logic [15:0] ANALOG_SEL
);

    // ******************************
    // Pin synchroniser
    // ******************************
    logic [15:0] sync1_r;
    logic [15:0] sync2_r;

    // Two flops before any logic reads the pads
    always_ff @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            sync1_r <= 16'h0000;
            sync2_r <= 16'h0000;
        end else if (CE) begin
            sync1_r <= PAD_IN;
            sync2_r <= sync1_r;
        end
    end

    // ******************************
    // Register file
    // ******************************
    logic [15:0] dir_r;
    logic [15:0] dir_nxt;
    logic [15:0] lat_r;
    logic [15:0] lat_nxt;
    logic [15:0] ana_r;
    logic [15:0] ana_nxt;
    logic [15:0] pen_r;
    logic [15:0] pen_nxt;
    logic [31:0] rdata_r;
    logic [31:0] rdata_nxt;
    logic wait_r;
    logic wait_nxt;
    spio_pkg::spio_bus_state_type bus_r;
    spio_pkg::spio_bus_state_type bus_nxt;
    logic [15:0] pin_view;
    logic [15:0] wmask;

    // Byte lanes to a 16-bit bit mask
    function automatic logic [15:0] lane_mask(input logic [3:0] be);
        lane_mask = {{8{be[1]}}, {8{be[0]}}};
    endfunction

    // Merge write data into a register under lanes and implemented bits
    function automatic logic [15:0] merge(input logic [15:0] old, input logic [15:0] wd, input logic [15:0] m);
        merge = ((old & ~m) | (wd & m)) & IMPL_MASK;
    endfunction

    // Pin view: analog inputs read low, unimplemented bits zero
    assign pin_view = sync2_r & ~(ana_r & dir_r) & IMPL_MASK;
    assign wmask = lane_mask(AVS_BYTEENABLE);

    // Bus handshake and register next values
    always_comb begin
        dir_nxt = dir_r;
        lat_nxt = lat_r;
        ana_nxt = ana_r;
        pen_nxt = pen_r;
        rdata_nxt = rdata_r;
        wait_nxt = wait_r;
        bus_nxt = bus_r;
        unique case (bus_r)
            spio_pkg::BUS_IDLE: begin
                if (AVS_READ || AVS_WRITE) begin
                    bus_nxt = spio_pkg::BUS_RESP;
                    wait_nxt = 1'b0;
                    rdata_nxt = spio_pkg::RD_ZERO;
                    if (AVS_WRITE) begin
                        unique case (AVS_ADDRESS)
                            spio_pkg::OFS_DIR: dir_nxt = merge(dir_r, AVS_WRITEDATA[15:0], wmask);
                            spio_pkg::OFS_LAT: lat_nxt = merge(lat_r, AVS_WRITEDATA[15:0], wmask);
                            spio_pkg::OFS_PIN: lat_nxt = merge(lat_r, AVS_WRITEDATA[15:0], wmask);
                            spio_pkg::OFS_ANA: ana_nxt = merge(ana_r, AVS_WRITEDATA[15:0], wmask) & ANALOG_MASK;
                            spio_pkg::OFS_PEN: pen_nxt = merge(pen_r, AVS_WRITEDATA[15:0], wmask);
                            default: ;
                        endcase
                    end else begin
                        unique case (AVS_ADDRESS)
                            spio_pkg::OFS_DIR: rdata_nxt = {16'h0000, dir_r & IMPL_MASK};
                            spio_pkg::OFS_LAT: rdata_nxt = {16'h0000, lat_r & IMPL_MASK};
                            spio_pkg::OFS_PIN: rdata_nxt = {16'h0000, pin_view};
                            spio_pkg::OFS_ANA: rdata_nxt = {16'h0000, ana_r};
                            spio_pkg::OFS_PEN: rdata_nxt = {16'h0000, pen_r};
                            default: rdata_nxt = spio_pkg::RD_ZERO;
                        endcase
                    end
                end
            end
            spio_pkg::BUS_RESP: begin
                bus_nxt = spio_pkg::BUS_DONE;
                wait_nxt = 1'b1;
            end
            spio_pkg::BUS_DONE: begin
                bus_nxt = spio_pkg::BUS_IDLE;
            end
            default: begin
                bus_nxt = spio_pkg::BUS_IDLE;
                wait_nxt = 1'b1;
            end
        endcase
    end

    // Register state; reset makes every pin an input
    always_ff @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            dir_r <= spio_pkg::RST_DIR;
            lat_r <= spio_pkg::RST_LAT;
            ana_r <= spio_pkg::RST_ANA;
            pen_r <= spio_pkg::RST_PEN;
            rdata_r <= spio_pkg::RD_ZERO;
            wait_r <= 1'b1;
            bus_r <= spio_pkg::BUS_IDLE;
        end else if (CE) begin
            dir_r <= dir_nxt;
            lat_r <= lat_nxt;
            ana_r <= ana_nxt;
            pen_r <= pen_nxt;
            rdata_r <= rdata_nxt;
            wait_r <= wait_nxt;
            bus_r <= bus_nxt;
        end
    end

    assign AVS_READDATA = rdata_r;
    assign AVS_WAITREQUEST = wait_r;

    // ******************************
    // Pad output multiplexers and converter path
    // ******************************
    logic [15:0] owner;
    logic [15:0] pad_d_nxt;
    logic [15:0] pad_e_nxt;
    logic [15:0] asmp_nxt;
    logic [15:0] asel_nxt;
    logic [15:0] pad_d_r;
    logic [15:0] pad_e_r;
    logic [15:0] asmp_r;
    logic [15:0] asel_r;

    // Per-bit ownership, pad muxes and converter selection
    always_comb begin
        owner = PERIPH.enable & PERIPH.drive & OUTPUT_PERIPH_MASK & pen_r;
        pad_d_nxt = ((owner & PERIPH.data) | (~owner & lat_r)) & IMPL_MASK;
        pad_e_nxt = (owner | (~owner & ~dir_r)) & IMPL_MASK;
        // Analog pin as output: converter sees its output latch level, not peripheral data
        asel_nxt = ana_r & IMPL_MASK;
        asmp_nxt = asel_nxt & ~dir_r & lat_r;
    end

    // Registered pad and converter outputs
    always_ff @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            pad_d_r <= 16'h0000;
            pad_e_r <= 16'h0000;
            asmp_r <= 16'h0000;
            asel_r <= 16'h0000;
        end else if (CE) begin
            pad_d_r <= pad_d_nxt;
            pad_e_r <= pad_e_nxt;
            asmp_r <= asmp_nxt;
            asel_r <= asel_nxt;
        end
    end

    // One driver for the whole pad carrier, both halves straight from flops
    assign PAD_OUT = {pad_d_r, pad_e_r};
    assign ANALOG_SAMPLE = asmp_r;
    assign ANALOG_SEL = asel_r;

endmodule

`default_nettype wire

// ### verification/shared_parallel_io_port_test.sv
// Self-checking bench of the shared parallel I/O port
`timescale 1ns/1ps
`default_nettype none
module shared_parallel_io_port_test;
    // ********
    // Bench state
    // ********
    typedef struct packed {logic [2:0] wa; logic [15:0] wd; logic [1:0] be; logic [2:0] ra; logic [15:0] ex;} spio_row_type;
    spio_row_type rows [7] = '{'{3'h0, 16'h0000, 2'h3, 3'h0, 16'h0000}, '{3'h1, 16'hFFFF, 2'h3, 3'h1, 16'hBFFF},
        '{3'h1, 16'h1234, 2'h1, 3'h1, 16'hBF34}, '{3'h2, 16'h00FF, 2'h3, 3'h1, 16'h00FF},
        '{3'h3, 16'hFFFF, 2'h3, 3'h3, 16'h00FF}, '{3'h4, 16'hFFFF, 2'h2, 3'h4, 16'hBF00},
        '{3'h5, 16'h1234, 2'h3, 3'h5, 16'h0000}};
    logic clk = 1'b0, arst_n = 1'b0, rd = 1'b0, wr = 1'b0, wq;
    logic [2:0] adr = 3'h0;
    logic [3:0] be = 4'h0;
    logic [31:0] wd = 32'h0000_0000, rdata;
    logic [15:0] ext = 16'h0000, pin, smp, sel, got;
    spio_pkg::spio_periph_type cfg = 48'h0000_0000_0000, per;
    spio_pkg::spio_pad_type pad;
    int err_total = 0, n_tests = 0;
    spio_port #(.IMPL_MASK(16'hBFFF), .OUTPUT_PERIPH_MASK(16'h7FFF)) uut (.CLK(clk), .ARST_N(arst_n), .CE(1'b1),
        .AVS_ADDRESS(adr), .AVS_READ(rd), .AVS_WRITE(wr), .AVS_WRITEDATA(wd), .AVS_BYTEENABLE(be),
        .AVS_READDATA(rdata), .AVS_WAITREQUEST(wq), .PERIPH(per), .PAD_IN(pin), .PAD_OUT(pad),
        .ANALOG_SAMPLE(smp), .ANALOG_SEL(sel));
    spio_far_model far (.clk(clk), .arst_n(arst_n), .ext_lvl(ext), .cfg(cfg), .pad(pad), .periph(per), .pad_in(pin));
    // Clock and watchdog
    always #12.5 clk = ~clk;
    initial begin
        #20000;
        err_total++;
        wrap_up;
    end
    // One bus access, held until waitrequest is seen low
    task automatic bus(input logic w, input logic [2:0] a, input logic [15:0] d, input logic [1:0] b);
        int n = 0;
        @(posedge clk);
        adr <= a;
        wr <= w;
        rd <= !w;
        wd <= {16'h0000, d};
        be <= {2'b00, b};
        do @(posedge clk); while (wq !== 1'b0 && ++n < 40);
        got = rdata[15:0];
        wr <= 1'b0;
        rd <= 1'b0;
        if (n >= 40) err_total++;
    endtask
    // Compare seen against expected
    task automatic chk(input logic [15:0] g, input logic [15:0] e);
        n_tests++;
        if (g !== e) begin
            err_total++;
            $display("ERROR t=%0t got %h exp %h", $time, g, e);
        end
    endtask
    // Verdict and end of run
    task automatic wrap_up;
        if (err_total == 0 && n_tests > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    // Reset, register rows, then pad, analog, sharing and reset cases
    initial begin
        repeat (6) @(posedge clk);
        arst_n <= 1'b1;
        chk(pad.out_en, 16'h0000);
        bus(1'b0, 3'h0, 16'h0000, 2'h3);
        chk(got, 16'hBFFF);
        foreach (rows[i]) begin
            bus(1'b1, rows[i].wa, rows[i].wd, rows[i].be);
            bus(1'b0, rows[i].ra, 16'h0000, 2'h3);
            chk(got, rows[i].ex);
        end
        repeat (3) @(posedge clk);
        chk(pad.out_en & 16'hBFFF, 16'hBFFF);
        chk(pad.out_data & 16'hBFFF, 16'h00FF);
        chk(smp, 16'h00FF);
        chk(sel, 16'h00FF);
        bus(1'b0, 3'h2, 16'h0000, 2'h3);
        chk(got, 16'h00FF);
        ext <= 16'hFFFF;
        bus(1'b1, 3'h0, 16'hFF0F, 2'h3);
        repeat (3) @(posedge clk);
        chk(smp, 16'h00F0);
        bus(1'b0, 3'h2, 16'h0000, 2'h3);
        chk(got, 16'hBFF0);
        cfg <= {16'h8011, 16'h8001, 16'hFFFF};
        bus(1'b1, 3'h4, 16'hFFFF, 2'h3);
        repeat (3) @(posedge clk);
        chk(pad.out_en & 16'hBFFF, 16'h00F1);
        chk(pad.out_data & pad.out_en & 16'hBFFF, 16'h00E1);
        bus(1'b0, 3'h2, 16'h0000, 2'h3);
        chk(got, 16'hBFE0);
        arst_n <= 1'b0;
        repeat (2) @(posedge clk);
        chk(pad.out_en, 16'h0000);
        arst_n <= 1'b1;
        bus(1'b0, 3'h0, 16'h0000, 2'h3);
        chk(got, 16'hBFFF);
        wrap_up;
    end
endmodule
`default_nettype wire

// ### verification/spio_far_model.sv
// Far side model: pads with outside levels and a sharing peripheral
`timescale 1ns/1ps
`default_nettype none
module spio_far_model (
    // Clock and bench control
    input wire logic clk,
    input wire logic arst_n,
    input wire logic [15:0] ext_lvl,
    input wire spio_pkg::spio_periph_type cfg,
    // Port side
    input wire spio_pkg::spio_pad_type pad,
    output spio_pkg::spio_periph_type periph,
    output logic [15:0] pad_in
);
    logic [15:0] junk_r;
    // Idle peripheral data toggles every cycle so it is never trusted
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) junk_r <= 16'h5A5A;
        else junk_r <= ~junk_r;
    end
    assign periph = {cfg.drive, (cfg.data & cfg.drive) | (junk_r & ~cfg.drive), cfg.enable};
    // Pin level is the pad driver where enabled, else the outside world
    assign pad_in = (pad.out_data & pad.out_en) | (ext_lvl & ~pad.out_en);
endmodule
`default_nettype wire

// ### verification/spio_port_properties.sv
// Checker of bus handshake, read masks, reset and converter outputs
`timescale 1ns/1ps
`default_nettype none
module spio_port_properties #(
    parameter logic [15:0] IMPL_MASK = 16'hFFFF,
    parameter logic [15:0] ANALOG_MASK = 16'h00FF
) (
    // Clock, reset and bus
    input wire logic CLK,
    input wire logic ARST_N,
    input wire logic [2:0] AVS_ADDRESS,
    input wire logic AVS_READ,
    input wire logic AVS_WRITE,
    input wire logic [31:0] AVS_READDATA,
    input wire logic AVS_WAITREQUEST,
    // Pads and converter
    input wire spio_pkg::spio_pad_type PAD_OUT,
    input wire logic [15:0] ANALOG_SAMPLE,
    input wire logic [15:0] ANALOG_SEL
);
    // ********
    // Properties
    // ********
    default clocking cb @(posedge CLK); endclocking
    default disable iff (!ARST_N);
    // Two idle cycles after each answer
    sequence s_dead;
        AVS_WAITREQUEST [*2];
    endsequence
    // A read being answered
    sequence s_rd;
        !AVS_WAITREQUEST && AVS_READ;
    endsequence
    AST_DEAD: assert property ($fell(AVS_WAITREQUEST) |=> s_dead) else $error("no dead cycle");
    AST_ANSWER: assert property ($fell(AVS_WAITREQUEST) |-> $past(AVS_READ) || $past(AVS_WRITE))
        else $error("answer without request");
    AST_RD_UPPER: assert property (s_rd |-> AVS_READDATA[31:16] == 16'h0000) else $error("upper bits");
    AST_RD_IMPL: assert property (s_rd |-> (AVS_READDATA[15:0] & ~IMPL_MASK) == 16'h0000)
        else $error("unimplemented bit read");
    AST_UNMAPPED: assert property (s_rd ##0 AVS_ADDRESS > 3'h4 |-> AVS_READDATA == 32'h0000_0000)
        else $error("unmapped read");
    AST_ANA_ZERO: assert property (s_rd ##0 AVS_ADDRESS == 3'h2 |->
        (AVS_READDATA[15:0] & ANALOG_SEL & ~PAD_OUT.out_en) == 16'h0000) else $error("analog pin read");
    AST_RESET_IN: assert property ($rose(ARST_N) |-> PAD_OUT.out_en == 16'h0000) else $error("reset drive");
    AST_SEL_MASK: assert property ((ANALOG_SEL & ~(ANALOG_MASK & IMPL_MASK)) == 16'h0000)
        else $error("select mask");
    AST_SAMPLE: assert property ((ANALOG_SAMPLE & ~(ANALOG_SEL & PAD_OUT.out_en)) == 16'h0000)
        else $error("sample mask");
endmodule
bind spio_port spio_port_properties #(.IMPL_MASK(IMPL_MASK), .ANALOG_MASK(ANALOG_MASK)) u_props (.CLK(CLK),
    .ARST_N(ARST_N), .AVS_ADDRESS(AVS_ADDRESS), .AVS_READ(AVS_READ), .AVS_WRITE(AVS_WRITE),
    .AVS_READDATA(AVS_READDATA), .AVS_WAITREQUEST(AVS_WAITREQUEST), .PAD_OUT(PAD_OUT),
    .ANALOG_SAMPLE(ANALOG_SAMPLE), .ANALOG_SEL(ANALOG_SEL));
`default_nettype wire
